// ---- design/log_page_fetch_decode.sv ----
// Log page fetch command decoder, copier and completion poster.
//
// What this block does
// - Post completion entry with dword zero at finish.
// - Use only pointer and dwords ten-thirteen.
// - Unsupported page selector aborts with bad field.
// - Without extended count, use 12-bit count.
// - Advertise extended count support only; offset is not advertised.
// - Buffer start comes from 128-bit pointer.
// - Count low half from dword ten top.
// - Count is zero-based, move one more.
// - Oversize request still returns whole page.
// - Keep bit zero clears event after success.
// - Page specific field decoded, other bits reserved.
// - Page selector is dword ten low byte.
// - Count high half from dword eleven low.
// - Offset low word is dword twelve.
// - Misaligned offset aborts or drops low bits.
// - Offset high word is dword thirteen.
`timescale 1ns/1ps
module log_page_fetch_decode
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Page storage read port, answered in the same cycle.
   output logic [63:0] page_addr,
   input wire logic [31:0] page_data,
   // Host buffer write port, one dword per pulse.
   output logic [127:0] buf_addr,
   output logic [31:0] buf_data,
   output logic buf_write,
   input wire logic buf_ready,
   // Completion entry: one-cycle pulse with dword zero and status.
   output logic cpl_valid,
   output logic [31:0] cpl_dword0,
   output logic [7:0] cpl_status,
   // Event clear pulse carrying the page selector.
   output logic event_clear,
   output logic [7:0] event_page,
   output logic busy
);
   import log_fetch_pkg::*;

   // Command dwords and buffer pointer as software wrote them.
   logic [31:0] dw10_reg, dw11_reg, dw12_reg, dw13_reg;
   logic [31:0] ptr_reg [4];
   // Control bits: extended count, offset support and strict alignment.
   logic ext_reg, ofs_reg, strict_reg;
   // Control bits in force for the command that a go write starts.
   logic ext_sel, ofs_sel, strict_sel;
   logic go;
   seq_t state_reg;
   // Dwords left to move, minus one.
   logic [31:0] left_reg;
   logic [63:0] pos_reg;
   logic [127:0] dst_reg;
   logic [7:0] status_reg;
   logic [31:0] done_count_reg;

   // Decoded command fields.
   logic [7:0] page_selector;
   logic [3:0] page_specific_field;
   logic keep_event_pending;
   logic [15:0] count_low_half, count_high_half;
   logic [31:0] offset_low_word, offset_high_word;
   logic [31:0] count_zb;
   logic [63:0] start_ofs;
   logic bad_sel, bad_align;

   // A selector is supported when it lies in the implemented range.
   function automatic logic sel_ok(input logic [7:0] s);
      sel_ok = (s >= SEL_MIN) && (s <= SEL_MAX);
   endfunction

   assign go = reg_write && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_GO];

   // Field extraction; bits 14:12 and dword eleven top are ignored.
   always_comb
   begin
      // A go write carries its own control bits, so they apply at once.
      ext_sel = go ? reg_wdata[CTRL_EXT] : ext_reg;
      ofs_sel = go ? reg_wdata[CTRL_OFS] : ofs_reg;
      strict_sel = go ? reg_wdata[CTRL_STRICT] : strict_reg;
      page_selector = dw10_reg[SEL_MSB:SEL_LSB];
      // Kept for pages that define it; nothing here uses it yet.
      page_specific_field = dw10_reg[PSF_MSB:PSF_LSB];
      keep_event_pending = dw10_reg[KEEP_BIT];
      count_low_half = dw10_reg[CNT_LO_MSB:CNT_LO_LSB];
      count_high_half = dw11_reg[CNT_HI_MSB:CNT_HI_LSB];
      offset_low_word = dw12_reg;
      offset_high_word = dw13_reg;
      if (ext_sel)
      begin
         count_zb = {count_high_half, count_low_half};
      end
      else
      begin
         // Only the short 12-bit count is honoured here.
         count_zb = {20'h00000, dw10_reg[CNT_SHORT_MSB:CNT_LO_LSB]};
      end
      if (ofs_sel)
      begin
         // Low two bits forced to zero when not aborting.
         start_ofs = {offset_high_word, offset_low_word[31:2],
                      OFS_ALIGN_ZERO};
      end
      else
      begin
         start_ofs = 64'h0;
      end
      bad_sel = !sel_ok(page_selector);
      bad_align = ofs_sel && strict_sel &&
                  (offset_low_word[OFS_ALIGN_MSB:0] != OFS_ALIGN_ZERO);
   end

   // Command, pointer and control registers; only these fields are stored.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dw10_reg <= 32'h0;
         dw11_reg <= 32'h0;
         dw12_reg <= 32'h0;
         dw13_reg <= 32'h0;
         ext_reg <= 1'b0;
         ofs_reg <= 1'b0;
         strict_reg <= 1'b0;
         for (int i = 0; i < 4; i++)
         begin
            ptr_reg[i] <= 32'h0;
         end
      end
      else if (reg_write && state_reg == ST_IDLE)
      begin
         unique case (reg_addr)
            ADDR_DW10: dw10_reg <= reg_wdata;
            ADDR_DW11: dw11_reg <= reg_wdata;
            ADDR_DW12: dw12_reg <= reg_wdata;
            ADDR_DW13: dw13_reg <= reg_wdata;
            ADDR_PTR0: ptr_reg[0] <= reg_wdata;
            ADDR_PTR1: ptr_reg[1] <= reg_wdata;
            ADDR_PTR2: ptr_reg[2] <= reg_wdata;
            ADDR_PTR3: ptr_reg[3] <= reg_wdata;
            ADDR_CTRL:
            begin
               ext_reg <= reg_wdata[CTRL_EXT];
               ofs_reg <= reg_wdata[CTRL_OFS];
               strict_reg <= reg_wdata[CTRL_STRICT];
            end
            default: ;
         endcase
      end
   end

   // Read port: data stand one cycle after the strobe, zero otherwise.
   always_ff @(posedge clk)
   begin
      if (reset || !reg_read)
      begin
         reg_rdata <= 32'h0;
      end
      else
      begin
         unique case (reg_addr)
            ADDR_DW10: reg_rdata <= dw10_reg;
            ADDR_DW11: reg_rdata <= dw11_reg;
            ADDR_DW12: reg_rdata <= dw12_reg;
            ADDR_DW13: reg_rdata <= dw13_reg;
            ADDR_PTR0: reg_rdata <= ptr_reg[0];
            ADDR_PTR1: reg_rdata <= ptr_reg[1];
            ADDR_PTR2: reg_rdata <= ptr_reg[2];
            ADDR_PTR3: reg_rdata <= ptr_reg[3];
            ADDR_CTRL: reg_rdata <= {28'h0, strict_reg, ofs_reg, ext_reg,
                                     busy};
            ADDR_STAT: reg_rdata <= {24'h0, status_reg};
            // Only the extended count is advertised, though offset support is implemented.
            ADDR_ATTR: reg_rdata <= 32'h1 << ATTR_EXT_BIT;
            ADDR_DONE: reg_rdata <= done_count_reg;
            default: reg_rdata <= 32'h0;
         endcase
      end
   end

   // Sequencer: decode, copy a dword per accepted beat, then post.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_reg <= ST_IDLE;
         left_reg <= 32'h0;
         pos_reg <= 64'h0;
         dst_reg <= 128'h0;
         status_reg <= STATUS_OK;
         busy <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (go)
               begin
                  busy <= 1'b1;
                  pos_reg <= start_ofs;
                  dst_reg <= {ptr_reg[3], ptr_reg[2], ptr_reg[1],
                              ptr_reg[0]};
                  left_reg <= count_zb;
                  if (bad_sel || bad_align)
                  begin
                     status_reg <= STATUS_BAD_FIELD;
                     state_reg <= ST_POST;
                  end
                  else
                  begin
                     status_reg <= STATUS_OK;
                     state_reg <= ST_COPY;
                  end
               end
            end
            ST_COPY:
            begin
               // A beat moves when the buffer port accepts it.
               if (buf_write && buf_ready)
               begin
                  pos_reg <= pos_reg + 64'h4;
                  dst_reg <= dst_reg + 128'h4;
                  left_reg <= left_reg - 32'h1;
                  if (left_reg == 32'h0)
                  begin
                     state_reg <= ST_POST;
                  end
               end
            end
            ST_POST:
            begin
               busy <= 1'b0;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Buffer write port; past the page end the data read as zero.
   // The page address settles one cycle before its dword is latched, so
   // a beat takes two cycles at best. Storage answers combinationally, and
   // latching on the address update would hand out the previous dword.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         buf_write <= 1'b0;
         buf_addr <= 128'h0;
         buf_data <= 32'h0;
         page_addr <= 64'h0;
      end
      else if (state_reg == ST_IDLE)
      begin
         buf_write <= 1'b0;
         // Point storage at the first dword while the command starts.
         if (go)
         begin
            page_addr <= start_ofs;
         end
      end
      else if (state_reg == ST_COPY)
      begin
         if (!buf_write)
         begin
            // Present the next beat from the settled page address.
            buf_write <= 1'b1;
            buf_addr <= dst_reg;
            if (page_addr[63:2] < 62'(PAGE_DWORDS))
            begin
               buf_data <= page_data;
            end
            else
            begin
               buf_data <= 32'h0;
            end
         end
         else if (buf_ready)
         begin
            // Accepted: drop the strobe and move storage to the next dword.
            buf_write <= 1'b0;
            page_addr <= pos_reg + 64'h4;
         end
      end
      else
      begin
         buf_write <= 1'b0;
      end
   end

   // Completion entry and event clearing after a finished command.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cpl_valid <= 1'b0;
         cpl_dword0 <= 32'h0;
         cpl_status <= STATUS_OK;
         event_clear <= 1'b0;
         event_page <= 8'h0;
         done_count_reg <= 32'h0;
      end
      else
      begin
         cpl_valid <= (state_reg == ST_POST);
         cpl_status <= status_reg;
         cpl_dword0 <= 32'h0;
         event_clear <= (state_reg == ST_POST) &&
                        (status_reg == STATUS_OK) &&
                        !keep_event_pending;
         event_page <= page_selector;
         if (state_reg == ST_POST)
         begin
            done_count_reg <= done_count_reg + 32'h1;
         end
      end
   end
endmodule

// ---- common/log_fetch_pkg.sv ----
// Constants, field positions and types of the log page fetch block.
package log_fetch_pkg;
   // Command field positions within dword ten.
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 7;
   localparam int PSF_LSB = 8;
   localparam int PSF_MSB = 11;
   localparam int KEEP_BIT = 15;
   localparam int CNT_LO_LSB = 16;
   localparam int CNT_LO_MSB = 31;
   localparam int CNT_SHORT_MSB = 27;
   // Upper count sits in dword eleven.
   localparam int CNT_HI_LSB = 0;
   localparam int CNT_HI_MSB = 15;
   // Offset low bits that must be zero for dword alignment.
   localparam logic [1:0] OFS_ALIGN_ZERO = 2'h0;
   localparam int OFS_ALIGN_MSB = 1;
   // Status codes posted in the completion entry.
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_BAD_FIELD = 8'h02;
   // Page length in dwords for every supported page.
   localparam logic [31:0] PAGE_DWORDS = 32'h0000_0080;
   // Supported page selector set.
   localparam logic [7:0] SEL_MIN = 8'h01;
   localparam logic [7:0] SEL_MAX = 8'h08;
   // Attribute bits advertised for identify data.
   localparam int ATTR_EXT_BIT = 2;
   // Register map of the plain register port.
   localparam logic [3:0] ADDR_DW10 = 4'h0;
   localparam logic [3:0] ADDR_DW11 = 4'h1;
   localparam logic [3:0] ADDR_DW12 = 4'h2;
   localparam logic [3:0] ADDR_DW13 = 4'h3;
   localparam logic [3:0] ADDR_PTR0 = 4'h4;
   localparam logic [3:0] ADDR_PTR1 = 4'h5;
   localparam logic [3:0] ADDR_PTR2 = 4'h6;
   localparam logic [3:0] ADDR_PTR3 = 4'h7;
   localparam logic [3:0] ADDR_CTRL = 4'h8;
   localparam logic [3:0] ADDR_STAT = 4'h9;
   localparam logic [3:0] ADDR_ATTR = 4'hA;
   localparam logic [3:0] ADDR_DONE = 4'hB;
   // Control register bit positions.
   localparam int CTRL_GO = 0;
   localparam int CTRL_EXT = 1;
   localparam int CTRL_OFS = 2;
   localparam int CTRL_STRICT = 3;
   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_COPY = 2'b01,
      ST_POST = 2'b10
   } seq_t;
endpackage

// ---- dv/log_fetch_chk.sv ----
// Port-level assertions for the log page fetch block.
`timescale 1ns/1ps
module log_fetch_chk
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic [127:0] buf_addr,
   input wire logic [31:0] buf_data,
   input wire logic buf_write,
   input wire logic buf_ready,
   input wire logic cpl_valid,
   input wire logic [31:0] cpl_dword0,
   input wire logic [7:0] cpl_status,
   input wire logic event_clear,
   input wire logic busy
);
   import log_fetch_pkg::*;
   logic [31:0] dw10_reg; // Shadow of the loaded dword ten.
   logic bad_sel; // Loaded selector is outside the supported set.
   // Writes during busy are dropped by the block, so the shadow skips them.
   always_ff @(posedge clk)
   begin
      if (reset)
         dw10_reg <= 32'h0;
      else if (reg_write && reg_addr == ADDR_DW10 && !busy)
         dw10_reg <= reg_wdata;
   end
   assign bad_sel = dw10_reg[SEL_MSB:SEL_LSB] < SEL_MIN ||
      dw10_reg[SEL_MSB:SEL_LSB] > SEL_MAX;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // A go write accepted while idle.
   sequence s_go;
      reg_write && reg_addr == ADDR_CTRL && reg_wdata[CTRL_GO] && !busy;
   endsequence
   property p_bad_sel;
      s_go ##0 bad_sel |-> ##2 cpl_valid && cpl_status == STATUS_BAD_FIELD;
   endproperty
   a_bad_sel: assert property (p_bad_sel)
      else $error("unsupported selector not refused");
   property p_event;
      (cpl_valid || event_clear) |-> cpl_valid &&
         event_clear == (cpl_status == STATUS_OK && !dw10_reg[KEEP_BIT]);
   endproperty
   a_event: assert property (p_event)
      else $error("event clear wrong");
   property p_hold;
      buf_write && !buf_ready |=>
         buf_write && $stable(buf_addr) && $stable(buf_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("beat dropped or changed while stalled");
   property p_step;
      buf_write && buf_ready ##1 !buf_write ##1 buf_write |->
         buf_addr == $past(buf_addr, 2) + 128'h4;
   endproperty
   a_step: assert property (p_step)
      else $error("buffer address did not advance by one dword");
   property p_cpl;
      cpl_valid |-> cpl_dword0 == 32'h0 ##1 !cpl_valid;
   endproperty
   a_cpl: assert property (p_cpl)
      else $error("completion entry malformed");
   property p_go_busy;
      s_go |=> busy;
   endproperty
   a_go_busy: assert property (p_go_busy)
      else $error("go not taken");
   property p_done;
      $fell(busy) |-> cpl_valid;
   endproperty
   a_done: assert property (p_done)
      else $error("finished without completion");
   property p_idle;
      buf_write |-> busy;
   endproperty
   a_idle: assert property (p_idle)
      else $error("beat outside a command");
endmodule
bind log_page_fetch_decode log_fetch_chk u_log_fetch_chk
(
   .clk, .reset, .reg_addr, .reg_wdata, .reg_write, .buf_addr, .buf_data,
   .buf_write, .buf_ready, .cpl_valid, .cpl_dword0, .cpl_status,
   .event_clear, .busy
);

// ---- dv/host_model.sv ----
// Host buffer and page storage stand-in with optional stalls.
`timescale 1ns/1ps
module host_model
(
   input wire logic clk,
   input wire logic slow,
   input wire logic [63:0] page_addr,
   output logic [31:0] page_data,
   input wire logic [127:0] buf_addr,
   input wire logic [31:0] buf_data,
   input wire logic buf_write,
   output logic buf_ready
);
   logic [127:0] q_a[$]; // Accepted buffer addresses.
   logic [31:0] q_d[$]; // Accepted dwords.
   logic [63:0] first_pa; // Page address at the first accepted beat.
   logic tick = 1'b0; // Stall pattern.
   // Data mixes both address words so a lost high word shows up.
   assign page_data = page_addr[63:32] ^ page_addr[31:0] ^ 32'hC3C3_0000;
   // A slow host refuses every other cycle.
   assign buf_ready = !slow || tick;
   // Log each accepted beat and the start offset of each transfer.
   always @(posedge clk)
   begin
      tick <= !tick;
      if (buf_write && buf_ready)
      begin
         // The bench empties the log per command, so size zero is beat 0.
         if (q_a.size() == 0)
            first_pa <= page_addr;
         q_a.push_back(buf_addr);
         q_d.push_back(buf_data);
      end
   end
endmodule

// ---- dv/log_page_fetch_decode_test.sv ----
// Self-checking bench for the log page fetch block.
`timescale 1ns/1ps
module log_page_fetch_decode_test;
   import log_fetch_pkg::*;
   localparam logic [127:0] PTR = {32'h3, 32'h2, 32'h1, 32'h1000};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic slow = 1'b0; // Host stalls when set.
   logic [31:0] reg_rdata, page_data, buf_data, cpl_dword0;
   logic [63:0] page_addr;
   logic [127:0] buf_addr;
   logic [7:0] cpl_status, event_page;
   logic buf_write, buf_ready, cpl_valid, event_clear, busy;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   log_page_fetch_decode u_log_page_fetch_decode
   (
      .clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .page_addr, .page_data, .buf_addr, .buf_data, .buf_write, .buf_ready,
      .cpl_valid, .cpl_dword0, .cpl_status, .event_clear, .event_page, .busy
   );
   host_model u_host_model
   (
      .clk, .slow, .page_addr, .page_data, .buf_addr, .buf_data, .buf_write,
      .buf_ready
   );
   always #5 clk = ~clk;
   // A hung handshake ends the run as a failure.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_total++;
         end_sim();
      end
   end
   task end_sim;
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %0h vs %0h", $time, got, exp);
      end
   endtask
   // One strobe cycle; a read answer stands until the edge after return.
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= w;
      reg_read <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
   endtask
   // Loads a command, starts it and judges every beat and the completion.
   task cmd(input logic [31:0] d10, d11, d12, d13,
      input logic [3:0] ctl, input int n);
      int k;
      logic [63:0] ofs;
      logic [63:0] a;
      ofs = ctl[CTRL_OFS] ? {d13, d12[31:2], 2'h0} : 64'h0;
      u_host_model.q_a.delete();
      u_host_model.q_d.delete();
      bus(1'b1, ADDR_DW10, d10);
      bus(1'b1, ADDR_DW11, d11);
      bus(1'b1, ADDR_DW12, d12);
      bus(1'b1, ADDR_DW13, d13);
      for (k = 0; k < 4; k++)
         bus(1'b1, ADDR_PTR0 + 4'(k), PTR[32*k +: 32]);
      bus(1'b1, ADDR_CTRL, {28'h0, ctl | 4'h1});
      // Look at the one-cycle completion away from the edge that makes it.
      k = 0;
      while (cpl_valid !== 1'b1 && k < 10000)
      begin
         @(negedge clk);
         k++;
      end
      chk(k < 10000, 1'b1);
      chk(cpl_status, n == 0 ? STATUS_BAD_FIELD : STATUS_OK);
      chk(event_clear, n > 0 && !d10[KEEP_BIT]);
      chk(event_page, d10[7:0]);
      chk(u_host_model.q_a.size(), n);
      if (n > 0)
         chk(u_host_model.first_pa, ofs);
      for (k = 0; k < n; k++)
      begin
         a = ofs + 64'(4 * k);
         chk(u_host_model.q_a[k], PTR + 128'(4 * k));
         if (a < 64'(4 * PAGE_DWORDS))
            chk(u_host_model.q_d[k], a[63:32] ^ a[31:0] ^ 32'hC3C3_0000);
      end
   endtask
   task t_regs;
      bus(1'b0, ADDR_ATTR, 32'h0);
      @(negedge clk);
      chk(reg_rdata, 32'h1 << ATTR_EXT_BIT);
      bus(1'b0, 4'hF, 32'h0);
      @(negedge clk);
      chk(reg_rdata, 32'h0);
   endtask
   // Count decoding, reserved bits set, and a stalling host.
   task t_decode;
      cmd(32'hF003_7A01, 32'hFFFF_FFFF, 32'h40, 32'h1, 4'h0, 4);
      slow <= 1'b1;
      cmd(32'h0005_8002, 32'hFFFF_0000, 32'h0, 32'h0, 4'h2, 6);
      slow <= 1'b0;
      // Extended count honours the low-half bits above the short field.
      cmd(32'h1000_0003, 32'h0, 32'h0, 32'h0, 4'h2, 4097);
   endtask
   // Offsets, misalignment dropped, high word, and an oversize request.
   task t_offset;
      cmd(32'h0003_0003, 32'h0, 32'h13, 32'h0, 4'h6, 4);
      cmd(32'h0001_0004, 32'h0, 32'h20, 32'h1, 4'h6, 2);
      cmd(32'h0100_8008, 32'h0, 32'h0, 32'h0, 4'h2, 257);
   endtask
   // Refused commands move no data.
   task t_abort;
      cmd(32'h0000_0009, 32'h0, 32'h0, 32'h0, 4'h0, 0);
      cmd(32'h0000_0000, 32'h0, 32'h0, 32'h0, 4'h0, 0);
      cmd(32'h0000_0001, 32'h0, 32'h13, 32'h0, 4'hE, 0);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_decode();
      t_offset();
      t_abort();
      end_sim();
   end
endmodule
